// >>> rtl/spso_exec.sv
// execution unit for stores, code memory access, stack, sleep, watchdog
`timescale 1ns/100ps
`default_nettype none
`include "spso_consts.svh"
// Operation
// - a displaced store writes the source register to Y or Z plus the unsigned offset, keeps the pointer, and takes two cycles.
// - a pre-decrement store lowers the pointer by one, writes at the new address, and takes two cycles.
// - a post-increment store writes at the pointer, then raises it by one, in two cycles, flags untouched.
// - a direct store writes the source register to the address in the instruction, in two cycles, flags untouched.
// - a code memory read loads the byte at Z into R0 or a named register, optionally increments Z, in three cycles.
// - a push places the source register on the stack in two cycles, flags untouched.
// - a pop takes the top stack byte into the destination in two cycles, flags untouched.
// - sleep issues in one cycle and hands a request to the sleep-mode logic.
// - watchdog restart completes in one cycle and pulses the watchdog restart, flags untouched.
module spso_exec (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic instr_valid_i,
   input wire spso_pkg::spso_instr_t instr_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic [7:0] r0_i,
   input wire logic [7:0] r1_i,
   input wire logic [15:0] ptr_x_i,
   input wire logic [15:0] ptr_y_i,
   input wire logic [15:0] ptr_z_i,
   input wire logic [15:0] sp_i,
   input wire logic [7:0] dmem_rdata_i,
   input wire logic [7:0] cmem_rdata_i,
   input wire logic cmem_wr_done_i,
   output logic busy_o,
   output spso_pkg::spso_dwr_t dwr_o,
   output logic dmem_rd_o,
   output logic [15:0] dmem_raddr_o,
   output logic cmem_rd_o,
   output logic cmem_wr_o,
   output logic [15:0] cmem_addr_o,
   output logic [15:0] cmem_wdata_o,
   output logic reg_we_o,
   output logic [4:0] reg_widx_o,
   output logic [7:0] reg_wdata_o,
   output logic ptr_we_o,
   output logic [1:0] ptr_widx_o,
   output logic [15:0] ptr_wdata_o,
   output logic sp_we_o,
   output logic [15:0] sp_wdata_o,
   output logic sleep_req_o,
   output logic wdt_restart_o
);
   spso_pkg::spso_instr_t cur;
   logic ctr_busy, ctr_last, start, cmw_wait, done;
   logic [1:0] ncyc;
   logic [15:0] ptr_sel, ptr_dec, ptr_inc;

   // pointer selection and arithmetic
   function automatic logic [15:0] pick_ptr(input logic [1:0] s,
      input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
      pick_ptr = (s == `SPSO_PTR_X) ? x : (s == `SPSO_PTR_Y) ? y : z;
   endfunction

   // cycle count per operation
   function automatic logic [1:0] op_cycles(input spso_pkg::spso_op_t o);
      case (o)
         spso_pkg::SPSO_OP_CMR, spso_pkg::SPSO_OP_CMR_INC:
            op_cycles = `SPSO_CYC_CMR;
         spso_pkg::SPSO_OP_PUSH, spso_pkg::SPSO_OP_POP:
            op_cycles = `SPSO_CYC_STACK;
         spso_pkg::SPSO_OP_SLEEP, spso_pkg::SPSO_OP_WDR,
         spso_pkg::SPSO_OP_CMW, spso_pkg::SPSO_OP_NONE:
            op_cycles = `SPSO_CYC_SINGLE;
         default: op_cycles = `SPSO_CYC_STORE;
      endcase
   endfunction

   assign start = instr_valid_i && !busy_o;
   assign ncyc = op_cycles(instr_i.op);
   assign ptr_sel = pick_ptr(instr_i.ptr_sel, ptr_x_i, ptr_y_i, ptr_z_i);
   assign ptr_dec = ptr_sel - `SPSO_ONE16;
   assign ptr_inc = ptr_sel + `SPSO_ONE16;
   assign done = cmw_wait && cmem_wr_done_i;

   spso_cycle_ctr #(.W(2)) u_ctr (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .start_i(start),
      .cycles_i(ncyc),
      .busy_o(ctr_busy),
      .last_o(ctr_last)
   );

   // busy covers counted cycles and the open-ended code memory write
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         busy_o <= 1'b0;
         cmw_wait <= 1'b0;
         cur <= '0;
      end else begin
         if (start) begin
            cur <= instr_i;
         end
         if (start && instr_i.op == spso_pkg::SPSO_OP_CMW) begin
            cmw_wait <= 1'b1;
         end else if (done) begin
            cmw_wait <= 1'b0;
         end
         busy_o <= (start && (ncyc != `SPSO_CYC_SINGLE ||
            instr_i.op == spso_pkg::SPSO_OP_CMW)) ||
            (ctr_busy && !ctr_last) || (cmw_wait && !done);
      end
   end

   // issue-cycle actions: memory strobes, pointer and stack updates; Z increment of a code read on its last cycle
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dwr_o <= '0;
         dmem_rd_o <= 1'b0;
         dmem_raddr_o <= '0;
         cmem_rd_o <= 1'b0;
         cmem_wr_o <= 1'b0;
         cmem_addr_o <= '0;
         cmem_wdata_o <= '0;
         ptr_we_o <= 1'b0;
         ptr_widx_o <= '0;
         ptr_wdata_o <= '0;
         sp_we_o <= 1'b0;
         sp_wdata_o <= '0;
         sleep_req_o <= 1'b0;
         wdt_restart_o <= 1'b0;
      end else begin
         dwr_o <= '0;
         dmem_rd_o <= 1'b0;
         cmem_rd_o <= 1'b0;
         cmem_wr_o <= 1'b0;
         ptr_we_o <= 1'b0;
         sp_we_o <= 1'b0;
         sleep_req_o <= 1'b0;
         wdt_restart_o <= 1'b0;
         ptr_widx_o <= instr_i.ptr_sel;
         if (start) begin
            case (instr_i.op)
               spso_pkg::SPSO_OP_ST_PLAIN:
                  dwr_o <= '{1'b1, ptr_sel, reg_rdata_i};
               spso_pkg::SPSO_OP_ST_POSTINC: begin
                  dwr_o <= '{1'b1, ptr_sel, reg_rdata_i};
                  ptr_we_o <= 1'b1;
                  ptr_wdata_o <= ptr_inc;
               end
               spso_pkg::SPSO_OP_ST_PREDEC: begin
                  dwr_o <= '{1'b1, ptr_dec, reg_rdata_i};
                  ptr_we_o <= 1'b1;
                  ptr_wdata_o <= ptr_dec;
               end
               spso_pkg::SPSO_OP_ST_DISP:
                  dwr_o <= '{1'b1, ptr_sel + {10'h000, instr_i.disp},
                     reg_rdata_i};
               spso_pkg::SPSO_OP_ST_DIRECT:
                  dwr_o <= '{1'b1, instr_i.addr, reg_rdata_i};
               spso_pkg::SPSO_OP_CMR, spso_pkg::SPSO_OP_CMR_INC: begin
                  cmem_rd_o <= 1'b1;
                  cmem_addr_o <= ptr_z_i;
               end
               spso_pkg::SPSO_OP_CMW: begin
                  cmem_wr_o <= 1'b1;
                  cmem_addr_o <= ptr_z_i;
                  cmem_wdata_o <= {r1_i, r0_i};
               end
               spso_pkg::SPSO_OP_PUSH: begin
                  dwr_o <= '{1'b1, sp_i, reg_rdata_i};
                  sp_we_o <= 1'b1;
                  sp_wdata_o <= sp_i - `SPSO_ONE16;
               end
               spso_pkg::SPSO_OP_POP: begin
                  dmem_rd_o <= 1'b1;
                  dmem_raddr_o <= sp_i + `SPSO_ONE16;
                  sp_we_o <= 1'b1;
                  sp_wdata_o <= sp_i + `SPSO_ONE16;
               end
               spso_pkg::SPSO_OP_SLEEP: sleep_req_o <= 1'b1;
               spso_pkg::SPSO_OP_WDR: wdt_restart_o <= 1'b1;
               default: dwr_o <= '0;
            endcase
         end else if (ctr_last && cur.op == spso_pkg::SPSO_OP_CMR_INC) begin
            ptr_we_o <= 1'b1;
            ptr_widx_o <= `SPSO_PTR_Z;
            ptr_wdata_o <= ptr_z_i + `SPSO_ONE16;
         end
      end
   end

   // register file write-back on the final cycle of loads
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         reg_we_o <= 1'b0;
         reg_widx_o <= '0;
         reg_wdata_o <= '0;
      end else begin
         reg_we_o <= 1'b0;
         if (ctr_last && cur.op == spso_pkg::SPSO_OP_POP) begin
            reg_we_o <= 1'b1;
            reg_widx_o <= cur.reg_idx;
            reg_wdata_o <= dmem_rdata_i;
         end else if (ctr_last && (cur.op == spso_pkg::SPSO_OP_CMR ||
               cur.op == spso_pkg::SPSO_OP_CMR_INC)) begin
            reg_we_o <= 1'b1;
            reg_widx_o <= cur.reg_idx;
            reg_wdata_o <= cmem_rdata_i;
         end
      end
   end

   a_push_sp_dec: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_PUSH |=>
      sp_we_o && sp_wdata_o == $past(sp_i) - `SPSO_ONE16 && dwr_o.en)
      else $error("push did not lower the stack pointer");
   a_predec_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_ST_PREDEC |=>
      dwr_o.addr == ptr_wdata_o && ptr_we_o)
      else $error("pre-decrement store used the wrong address");
   a_store_two_cyc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_ST_DIRECT |=>
      busy_o ##1 !busy_o)
      else $error("direct store did not take two cycles");
   a_cmr_three_cyc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_CMR |=>
      busy_o ##1 busy_o ##1 (!busy_o && reg_we_o))
      else $error("code read did not take three cycles");
   a_pop_writeback: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_POP |=> dmem_rd_o ##1 reg_we_o)
      else $error("pop did not write back in two cycles");
   a_wdr_single: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_WDR |=> wdt_restart_o && !busy_o)
      else $error("watchdog restart not a one-cycle pulse");
   a_sleep_single: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_SLEEP |=> sleep_req_o && !busy_o)
      else $error("sleep request not issued in one cycle");
   a_postinc_ptr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_ST_POSTINC |=>
      ptr_wdata_o == dwr_o.addr + `SPSO_ONE16)
      else $error("post-increment pointer wrong");
   a_disp_keeps_ptr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_ST_DISP |=> !ptr_we_o && dwr_o.en)
      else $error("displaced store touched the pointer");
   a_cmw_holds: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cmw_wait && !cmem_wr_done_i |=> busy_o)
      else $error("code write released before done");
   a_push_two_cyc: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      start && instr_i.op == spso_pkg::SPSO_OP_PUSH |=> busy_o ##1 !busy_o)
      else $error("push did not take two cycles");
endmodule
`default_nettype wire

// >>> rtl/spso_consts.svh
// constants for the store, code memory and stack execution unit
`ifndef SPSO_CONSTS_SVH
`define SPSO_CONSTS_SVH
`define SPSO_CYC_STORE 2'h2
`define SPSO_CYC_STACK 2'h2
`define SPSO_CYC_CMR 2'h3
`define SPSO_CYC_SINGLE 2'h1
`define SPSO_R0_IDX 5'h00
`define SPSO_R1_IDX 5'h01
`define SPSO_PTR_X 2'h0
`define SPSO_PTR_Y 2'h1
`define SPSO_PTR_Z 2'h2
`define SPSO_ONE16 16'h0001
`endif

// >>> rtl/spso_pkg.sv
// types shared by the store, code memory and stack execution unit
`default_nettype none
package spso_pkg;
   typedef enum logic [3:0] {
      SPSO_OP_NONE,
      SPSO_OP_ST_PLAIN,
      SPSO_OP_ST_POSTINC,
      SPSO_OP_ST_PREDEC,
      SPSO_OP_ST_DISP,
      SPSO_OP_ST_DIRECT,
      SPSO_OP_CMR,
      SPSO_OP_CMR_INC,
      SPSO_OP_CMW,
      SPSO_OP_PUSH,
      SPSO_OP_POP,
      SPSO_OP_SLEEP,
      SPSO_OP_WDR
   } spso_op_t;

   // one decoded instruction as handed in by the fetch stage
   typedef struct packed {
      spso_op_t op;
      logic [1:0] ptr_sel;
      logic [4:0] reg_idx;
      logic [5:0] disp;
      logic [15:0] addr;
   } spso_instr_t;

   // one data-space write
   typedef struct packed {
      logic en;
      logic [15:0] addr;
      logic [7:0] data;
   } spso_dwr_t;
endpackage
`default_nettype wire

// >>> rtl/spso_cycle_ctr.sv
// cycle counter that stretches an instruction over its cycle count
`timescale 1ns/100ps
`default_nettype none
module spso_cycle_ctr #(
   parameter int W = 2
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [W-1:0] cycles_i,
   output logic busy_o,
   output logic last_o
);
   logic [W-1:0] left;
   // refuse a counter too narrow for a three-cycle instruction
   if (W < 2) begin : g_w_check
      $error("spso_cycle_ctr: W must be at least 2");
   end
   // cycles remaining after the current one
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         left <= '0;
      end else if (start_i && !busy_o) begin
         left <= cycles_i - W'(1);
      end else if (left != '0) begin
         left <= left - W'(1);
      end
   end
   assign busy_o = (left != '0);
   assign last_o = (left == W'(1));
endmodule
`default_nettype wire

// >>> testbench/spso_mem_model.sv
// data and code memory model facing the execution unit
`timescale 1ns/100ps
`default_nettype none
module spso_mem_model (
   input wire logic sys_clk_i,
   input wire spso_pkg::spso_dwr_t dwr_i,
   input wire logic dmem_rd_i,
   input wire logic [15:0] dmem_raddr_i,
   input wire logic cmem_rd_i,
   input wire logic cmem_wr_i,
   input wire logic [15:0] cmem_addr_i,
   input wire logic [3:0] wr_lat_i,
   output logic [7:0] dmem_rdata_o,
   output logic [7:0] cmem_rdata_o,
   output logic cmem_wr_done_o
);
   logic [7:0] dmem [256];
   logic [3:0] cnt;
   initial begin
      cnt = 4'h0;
      cmem_rdata_o = 8'h00;
   end
   // data space: byte stands in the strobe's own cycle, inverse otherwise
   assign dmem_rdata_o = dmem_rd_i ? dmem[dmem_raddr_i[7:0]] :
      ~dmem[dmem_raddr_i[7:0]];
   always @(posedge sys_clk_i) begin
      if (dwr_i.en) begin
         dmem[dwr_i.addr[7:0]] <= dwr_i.data;
      end
   end
   // code space: pattern stands the cycle after the strobe, done later
   always @(posedge sys_clk_i) begin
      cmem_rdata_o <= cmem_rd_i ? (cmem_addr_i[7:0] ^ 8'h5a) : ~cmem_rdata_o;
      cnt <= cmem_wr_i ? wr_lat_i : ((cnt != 4'h0) ? cnt - 4'h1 : cnt);
   end
   assign cmem_wr_done_o = (cnt == 4'h1);
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// self-checking bench for the store, code memory and stack unit
`timescale 1ns/100ps
`default_nettype none
`include "spso_consts.svh"
module testbench;
   logic clk = 1'b0, rst = 1'b1, vld = 1'b0;
   spso_pkg::spso_instr_t ins = '0;
   logic [7:0] rr = 8'h00, r0 = 8'h00, r1 = 8'h00, dmrd, cmrd, rwd, wd, rd;
   logic [15:0] px = 16'h0000, py = 16'h0000, pz = 16'h0000, sp = 16'h0000;
   logic [3:0] lat = 4'h3;
   logic busy, drd, crd, cwr, cdone, rwe, pwe, swe, slp, wdt;
   logic [15:0] dra, ca, cwd, pwd, swd, wa, pd, sd, da, cma, cd;
   logic [4:0] rwi, ri;
   logic [1:0] pwi, pi;
   spso_pkg::spso_dwr_t dwr;
   int miscompares = 0, total_checks = 0;
   int at [10];
   int n [10];
   spso_exec spso_exec_inst (.sys_clk_i(clk), .rst_i(rst),
      .instr_valid_i(vld), .instr_i(ins), .reg_rdata_i(rr), .r0_i(r0),
      .r1_i(r1), .ptr_x_i(px), .ptr_y_i(py), .ptr_z_i(pz), .sp_i(sp),
      .dmem_rdata_i(dmrd), .cmem_rdata_i(cmrd), .cmem_wr_done_i(cdone),
      .busy_o(busy), .dwr_o(dwr), .dmem_rd_o(drd), .dmem_raddr_o(dra),
      .cmem_rd_o(crd), .cmem_wr_o(cwr), .cmem_addr_o(ca), .cmem_wdata_o(cwd),
      .reg_we_o(rwe), .reg_widx_o(rwi), .reg_wdata_o(rwd), .ptr_we_o(pwe),
      .ptr_widx_o(pwi), .ptr_wdata_o(pwd), .sp_we_o(swe), .sp_wdata_o(swd),
      .sleep_req_o(slp), .wdt_restart_o(wdt));
   spso_mem_model spso_mem_model_inst (.sys_clk_i(clk), .dwr_i(dwr),
      .dmem_rd_i(drd), .dmem_raddr_i(dra), .cmem_rd_i(crd), .cmem_wr_i(cwr),
      .cmem_addr_i(ca), .wr_lat_i(lat), .dmem_rdata_o(dmrd),
      .cmem_rdata_o(cmrd), .cmem_wr_done_o(cdone));
   initial begin
      forever #10 clk = ~clk;
   end
   task end_of_test;
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input logic [127:0] got, input logic [127:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // issue one op at this edge, then log the first cycle of each strobe
   task go(input spso_pkg::spso_op_t op, input logic [1:0] ps,
         input logic [4:0] ix, input logic [5:0] q, input logic [15:0] a);
      logic [9:0] ev;
      vld <= 1'b1;
      ins <= '{op, ps, ix, q, a};
      @(posedge clk);
      vld <= 1'b0;
      at = '{default: 0};
      n = '{default: 0};
      for (int k = 1; k <= 12; k++) begin
         #1;
         ev = {!busy, cdone, cwr, crd, wdt, slp, rwe, swe, pwe, dwr.en};
         for (int j = 0; j < 10; j++) begin
            if (ev[j] === 1'b1 && at[j] == 0) at[j] = k;
            if (ev[j] === 1'b1) n[j]++;
         end
         if (dwr.en) {wa, wd} = {dwr.addr, dwr.data};
         if (pwe) {pi, pd} = {pwi, pwd};
         if (swe) sd = swd;
         if (rwe) {ri, rd} = {rwi, rwd};
         if (cwr) {cma, cd} = {ca, cwd};
         if (crd) cma = ca;
         if (drd) da = dra;
         @(posedge clk);
      end
      if (at[9] == 0) begin
         miscompares++;
         end_of_test();
      end
   endtask
   task t_stores;
      px <= 16'h00ff;
      py <= 16'h0100;
      rr <= 8'h5c;
      go(spso_pkg::SPSO_OP_ST_POSTINC, `SPSO_PTR_X, 5'h03, 6'h00, 16'h0000);
      chk(wa, 16'h00ff);
      chk({pi, pd, wd}, {`SPSO_PTR_X, 16'h0100, 8'h5c});
      chk({at[0], at[1], at[9]}, {32'd1, 32'd1, 32'd2});
      go(spso_pkg::SPSO_OP_ST_PREDEC, `SPSO_PTR_Y, 5'h04, 6'h00, 16'h0000);
      chk({wa, pd, pi}, {16'h00ff, 16'h00ff, `SPSO_PTR_Y});
      chk(at[9], 2);
      go(spso_pkg::SPSO_OP_ST_DIRECT, `SPSO_PTR_X, 5'h05, 6'h00, 16'hbeef);
      chk({wa, wd}, {16'hbeef, 8'h5c});
      chk({n[1], at[9]}, {32'd0, 32'd2});
   endtask
   task t_disp;
      py <= 16'h0200;
      pz <= 16'h0300;
      for (int i = 1; i <= 2; i++) begin
         go(spso_pkg::SPSO_OP_ST_DISP, i[1:0], 5'h07, 6'h3f, 16'h0000);
         chk(wa, (i == 1) ? 16'h023f : 16'h033f);
         chk({n[1], at[9]}, {32'd0, 32'd2});
      end
   endtask
   task t_stack;
      sp <= 16'h0080;
      rr <= 8'hc3;
      go(spso_pkg::SPSO_OP_PUSH, `SPSO_PTR_X, 5'h09, 6'h00, 16'h0000);
      chk({wa, wd, sd}, {16'h0080, 8'hc3, 16'h007f});
      chk(at[9], 2);
      sp <= 16'h007f;
      rr <= 8'h00;
      go(spso_pkg::SPSO_OP_POP, `SPSO_PTR_X, 5'h0a, 6'h00, 16'h0000);
      chk({da, sd}, {16'h0080, 16'h0080});
      chk({ri, rd}, {5'h0a, 8'hc3});
      chk({at[3], at[9]}, {32'd2, 32'd2});
   endtask
   task t_code;
      pz <= 16'h0123;
      go(spso_pkg::SPSO_OP_CMR, `SPSO_PTR_Z, `SPSO_R0_IDX, 6'h00, 16'h0000);
      chk({ri, rd}, {`SPSO_R0_IDX, 8'h79});
      chk({at[3], at[9], n[1]}, {32'd3, 32'd3, 32'd0});
      chk({at[6], n[6], cma}, {32'd1, 32'd1, 16'h0123});
      go(spso_pkg::SPSO_OP_CMR_INC, `SPSO_PTR_Z, 5'h11, 6'h00, 16'h0000);
      chk({ri, rd, pi, pd}, {5'h11, 8'h79, `SPSO_PTR_Z, 16'h0124});
      chk({at[1], at[3], at[9]}, {32'd3, 32'd3, 32'd3});
      for (int i = 3; i <= 6; i += 3) begin
         r1 <= 8'ha5;
         r0 <= 8'h3c;
         pz <= 16'h0040;
         lat <= i[3:0];
         go(spso_pkg::SPSO_OP_CMW, `SPSO_PTR_Z, 5'h00, 6'h00, 16'h0000);
         chk({cma, cd}, {16'h0040, 16'ha53c});
         chk({at[7], at[9]}, {32'd1, at[8] + 1});
      end
   endtask
   task t_single;
      spso_pkg::spso_op_t so [3];
      so = '{spso_pkg::SPSO_OP_SLEEP, spso_pkg::SPSO_OP_WDR,
         spso_pkg::SPSO_OP_NONE};
      for (int i = 0; i < 3; i++) begin
         go(so[i], `SPSO_PTR_X, 5'h00, 6'h00, 16'h0000);
         chk({n[4], at[4]}, (i == 0) ? {32'd1, 32'd1} : 64'h0);
         chk({n[5], at[5]}, (i == 1) ? {32'd1, 32'd1} : 64'h0);
         chk({at[9], n[0] + n[3]}, {32'd1, 32'd0});
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1;
      chk({busy, dwr.en, rwe, pwe, swe, slp, wdt, crd, cwr, drd}, 0);
      @(posedge clk);
      rst <= 1'b0;
      t_stores();
      t_disp();
      t_stack();
      t_code();
      t_single();
      end_of_test();
   end
endmodule
`default_nettype wire
